// ### design/iorb_defs.vh
/*
 File holds: register offsets, field positions, reset values and range select codes of the inertial output and offset bank.
 Assumes: included by bare name by every design file of the bank; definitions only.
*/
`ifndef IORB_DEFS_VH
`define IORB_DEFS_VH

// Byte addresses of the lower byte of each 16-bit register
`define IORB_ADDR_SUPPLY 7'h02
`define IORB_ADDR_ROTATION 7'h04
`define IORB_ADDR_ACCEL_X 7'h0A
`define IORB_ADDR_ACCEL_Y 7'h0C
`define IORB_ADDR_ACCEL_Z 7'h0E
`define IORB_ADDR_TEMP 7'h10
`define IORB_ADDR_PITCH 7'h12
`define IORB_ADDR_ROLL 7'h14
`define IORB_ADDR_AUX 7'h16
`define IORB_ADDR_ROT_OFF 7'h1A
`define IORB_ADDR_PITCH_OFF 7'h1C
`define IORB_ADDR_ROLL_OFF 7'h1E
`define IORB_ADDR_ACCX_OFF 7'h20
`define IORB_ADDR_ACCY_OFF 7'h22
`define IORB_ADDR_ACCZ_OFF 7'h24
`define IORB_ADDR_BURST 7'h3E

// Flag positions in every output word
`define IORB_NEW_BIT 15
`define IORB_ERR_BIT 14

// Data widths of the output and offset fields
`define IORB_W_ROT 14
`define IORB_W_ACC 14
`define IORB_W_ANG 13
`define IORB_W_12 12
`define IORB_W_ROT_OFF 13
`define IORB_W_ACC_OFF 12
`define IORB_W_ALIGN 10

// Range select codes
`define IORB_RANGE_300 3'h4
`define IORB_RANGE_150 3'h2
`define IORB_RANGE_75 3'h1

// Number of output words in the bank and in a burst; reset value of the offset registers
`define IORB_NUM_OUT 9
`define IORB_OFF_RESET 16'h0000

// Serial word length
`define IORB_WORD_BITS 16

`endif

// ### design/iorb_word_mem.v
/*
 File holds: small register memory of the nine output words, one write port, one registered read port.
 Assumes: single clock, synchronous active-high reset; writer and reader on the same clock.
*/
`timescale 1ns/1ps
`include "iorb_defs.vh"

module iorb_word_mem #(
	parameter DEPTH = 9,
	parameter AW = 4,
	parameter DW = 14
) (
	input wire clk_sys_i,
	input wire srst_i,
	input wire wr_en_i,
	input wire [AW-1:0] wr_addr_i,
	input wire [DW-1:0] wr_data_i,
	input wire [AW-1:0] rd_addr_i,
	output reg [DW-1:0] rd_data_o
);
	reg [DW-1:0] mem_reg [0:DEPTH-1];
	integer i;

	// Storage clears on reset so a read before the first sample shows zero
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_reg[i] <= {DW{1'b0}};
			end
			rd_data_o <= {DW{1'b0}};
		end else begin
			if (wr_en_i) begin
				mem_reg[wr_addr_i] <= wr_data_i;
			end
			rd_data_o <= mem_reg[rd_addr_i];
		end
	end
endmodule // iorb_word_mem

// ### design/iorb_regs.v
/*
 File holds: output data and bias/alignment register bank with its serial slave and burst read.
 Assumes: samples come from the sample engine on clk_sys_i; serial pins are raw and sampled here;
 the alignment words are loaded by factory calibration through align_load_i.
*/
`timescale 1ns/1ps
`include "iorb_defs.vh"

// Functional notes
// [RULE_01] New-data flag set while word unread
// [RULE_02] Error flag mirrors any diagnostic status bit
// [RULE_03] Rotation word 14-bit two's complement
// [RULE_04] Rotation weight scales with selected range
// [RULE_05] Accelerometer words 14-bit two's complement
// [RULE_06] Pitch and roll are tilt angles
// [RULE_07] Angle words 13-bit two's complement
// [RULE_08] Supply word 12-bit offset binary
// [RULE_09] Temperature word 12-bit two's complement
// [RULE_10] Auxiliary converter word 12-bit offset binary
// [RULE_11] Bias offsets added to sensor outputs
// [RULE_12] Rotation offset uses low 13 bits
// [RULE_13] Accelerometer offsets use low 12 bits
// [RULE_14] Alignment registers hold 10-bit angle
// [RULE_15] Burst read shifts all outputs in order
// [RULE_16] Reading a word clears its flag
module iorb_regs (
	input wire clk_sys_i,
	input wire srst_i,
	input wire sample_valid_i,
	input wire [15:0] supply_raw_i,
	input wire [13:0] rotation_raw_i,
	input wire [13:0] accel_x_raw_i,
	input wire [13:0] accel_y_raw_i,
	input wire [13:0] accel_z_raw_i,
	input wire [15:0] temperature_raw_i,
	input wire [12:0] pitch_raw_i,
	input wire [12:0] roll_raw_i,
	input wire [15:0] aux_raw_i,
	input wire [2:0] range_sel_i,
	input wire [15:0] diagnostic_status_i,
	input wire align_load_i,
	input wire [15:0] pitch_align_i,
	input wire [15:0] roll_align_i,
	input wire spi_sclk_i,
	input wire spi_cs_n_i,
	input wire spi_mosi_i,
	output reg spi_miso_o,
	output reg [8:0] new_sample_flag_o,
	output reg error_alarm_flag_o
);
	// One-hot states of the serial slave
	localparam ST_IDLE = 3'b001;
	localparam ST_SHIFT = 3'b010;
	localparam ST_BURST = 3'b100;

	// Pin synchronisers, two flops each
	reg [1:0] sclk_sync_reg;
	reg [1:0] cs_sync_reg;
	reg [1:0] mosi_sync_reg;
	reg sclk_prev_reg;
	wire sclk_rise;
	wire sclk_fall;
	wire cs_n;

	// Bank state
	reg [2:0] state_reg;
	reg [15:0] shift_in_reg;
	reg [15:0] shift_out_reg;
	reg [4:0] bit_cnt_reg;
	reg [3:0] burst_idx_reg;
	reg [15:0] resp_reg;
	reg [8:0] unread_reg;
	reg [15:0] rot_off_reg;
	reg [15:0] accx_off_reg;
	reg [15:0] accy_off_reg;
	reg [15:0] accz_off_reg;
	reg [15:0] pitch_align_reg;
	reg [15:0] roll_align_reg;
	reg [3:0] wr_idx_reg;
	reg wr_busy_reg;
	reg [13:0] snap_reg [0:8];
	integer k;
	integer j;

	wire [3:0] mem_rd_addr;
	wire [13:0] mem_rd_data;
	wire [13:0] wr_data;
	wire err_any;
	wire [6:0] cmd_addr;
	wire cmd_write;

	// Edge detection reads only the second synchroniser stage
	assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
	assign sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg;
	assign cs_n = cs_sync_reg[1];
	assign err_any = |diagnostic_status_i; // [RULE_02]
	assign cmd_write = shift_in_reg[15];
	assign cmd_addr = shift_in_reg[14:8];

	// Map a byte address to an output word index, 4'hF when not an output word
	function [3:0] out_index;
		input [6:0] addr;
		begin
			case (addr)
				`IORB_ADDR_SUPPLY: out_index = 4'h0;
				`IORB_ADDR_ROTATION: out_index = 4'h1;
				`IORB_ADDR_ACCEL_X: out_index = 4'h2;
				`IORB_ADDR_ACCEL_Y: out_index = 4'h3;
				`IORB_ADDR_ACCEL_Z: out_index = 4'h4;
				`IORB_ADDR_TEMP: out_index = 4'h5;
				`IORB_ADDR_PITCH: out_index = 4'h6;
				`IORB_ADDR_ROLL: out_index = 4'h7;
				`IORB_ADDR_AUX: out_index = 4'h8;
				default: out_index = 4'hF;
			endcase
		end
	endfunction

	// Weight a rotation offset count to output counts; offset weight is a quarter of the 300 range step
	function [13:0] rot_scaled_off;
		input [15:0] off;
		input [2:0] rng;
		reg [14:0] ext;
		begin
			ext = {{2{off[12]}}, off[12:0]}; // [RULE_12]
			case (rng)
				`IORB_RANGE_150: rot_scaled_off = ext[14:1]; // [RULE_04]
				`IORB_RANGE_75: rot_scaled_off = ext[13:0]; // [RULE_04]
				default: rot_scaled_off = {ext[14], ext[14:2]}; // [RULE_04]
			endcase
		end
	endfunction

	// Build a full 16-bit output word from stored data and flags
	function [15:0] out_word;
		input [3:0] idx;
		input [13:0] data;
		input nd;
		input ea;
		reg [13:0] body;
		begin
			case (idx)
				4'h6, 4'h7: body = {1'b0, data[12:0]}; // [RULE_07]
				4'h0, 4'h5, 4'h8: body = {2'b00, data[11:0]}; // [RULE_08] [RULE_09] [RULE_10]
				default: body = data; // [RULE_03] [RULE_05]
			endcase
			out_word = {nd, ea, body}; // [RULE_01] [RULE_02]
		end
	endfunction

	// Offset-adjusted sample data for the word being written this cycle
	function [13:0] adjusted;
		input [3:0] idx;
		input [13:0] raw;
		input [13:0] rot_off;
		input [15:0] ax;
		input [15:0] ay;
		input [15:0] az;
		begin
			case (idx)
				4'h1: adjusted = raw + rot_off; // [RULE_11]
				4'h2: adjusted = raw + {{2{ax[11]}}, ax[11:0]}; // [RULE_11] [RULE_13]
				4'h3: adjusted = raw + {{2{ay[11]}}, ay[11:0]}; // [RULE_11] [RULE_13]
				4'h4: adjusted = raw + {{2{az[11]}}, az[11:0]}; // [RULE_11] [RULE_13]
				default: adjusted = raw;
			endcase
		end
	endfunction

	assign wr_data = adjusted(wr_idx_reg, snap_reg[wr_idx_reg], rot_scaled_off(rot_off_reg, range_sel_i),
		accx_off_reg, accy_off_reg, accz_off_reg);

	// Reads address the memory by burst position or by the command just received
	assign mem_rd_addr = (state_reg == ST_BURST) ? burst_idx_reg : out_index(shift_in_reg[14:8]);

	iorb_word_mem #(
		.DEPTH(`IORB_NUM_OUT),
		.AW(4),
		.DW(14)
	) u_mem (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.wr_en_i(wr_busy_reg),
		.wr_addr_i(wr_idx_reg),
		.wr_data_i(wr_data),
		.rd_addr_i(mem_rd_addr),
		.rd_data_o(mem_rd_data)
	);

	// Pin synchronisers
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			sclk_sync_reg <= 2'h3;
			cs_sync_reg <= 2'h3;
			mosi_sync_reg <= 2'h0;
			sclk_prev_reg <= 1'b1;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[0], spi_sclk_i};
			cs_sync_reg <= {cs_sync_reg[0], spi_cs_n_i};
			mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi_i};
			sclk_prev_reg <= sclk_sync_reg[1];
		end
	end

	// Sample capture: the set of nine words is snapshotted, then written one per cycle so offsets apply
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			wr_busy_reg <= 1'b0;
			wr_idx_reg <= 4'h0;
			for (j = 0; j < 9; j = j + 1) begin
				snap_reg[j] <= 14'h0000;
			end
		end else if (sample_valid_i) begin
			snap_reg[0] <= {2'b00, supply_raw_i[11:0]}; // [RULE_08]
			snap_reg[1] <= rotation_raw_i; // [RULE_03]
			snap_reg[2] <= accel_x_raw_i; // [RULE_05]
			snap_reg[3] <= accel_y_raw_i;
			snap_reg[4] <= accel_z_raw_i;
			snap_reg[5] <= {2'b00, temperature_raw_i[11:0]}; // [RULE_09]
			snap_reg[6] <= {1'b0, pitch_raw_i}; // [RULE_06] [RULE_07]
			snap_reg[7] <= {1'b0, roll_raw_i}; // [RULE_06]
			snap_reg[8] <= {2'b00, aux_raw_i[11:0]}; // [RULE_10]
			wr_busy_reg <= 1'b1;
			wr_idx_reg <= 4'h0;
		end else if (wr_busy_reg) begin
			if (wr_idx_reg == 4'h8) begin
				wr_busy_reg <= 1'b0;
			end
			wr_idx_reg <= wr_idx_reg + 4'h1;
		end
	end

	// Serial slave: mode 3, 16-bit frames, answer shifted out in the following frame
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_reg <= ST_IDLE;
			shift_in_reg <= 16'h0000;
			shift_out_reg <= 16'h0000;
			bit_cnt_reg <= 5'h00;
			burst_idx_reg <= 4'h0;
			resp_reg <= 16'h0000;
			rot_off_reg <= `IORB_OFF_RESET;
			accx_off_reg <= `IORB_OFF_RESET;
			accy_off_reg <= `IORB_OFF_RESET;
			accz_off_reg <= `IORB_OFF_RESET;
			pitch_align_reg <= 16'h0000;
			roll_align_reg <= 16'h0000;
			spi_miso_o <= 1'b0;
			unread_reg <= 9'h000;
			new_sample_flag_o <= 9'h000;
			error_alarm_flag_o <= 1'b0;
		end else begin
			// Alignment words come from calibration only; the host sees them read-only
			if (align_load_i) begin
				pitch_align_reg <= {6'h00, pitch_align_i[9:0]}; // [RULE_14]
				roll_align_reg <= {6'h00, roll_align_i[9:0]}; // [RULE_14]
			end
			// A new sample sets the flag of the word being written; set wins over a read clear
			for (k = 0; k < 9; k = k + 1) begin
				if (wr_busy_reg && wr_idx_reg == k[3:0]) begin
					unread_reg[k] <= 1'b1; // [RULE_01]
				end else if (state_reg == ST_SHIFT && bit_cnt_reg == 5'h11 && out_index(cmd_addr) == k[3:0]
					&& !cmd_write) begin
					unread_reg[k] <= 1'b0; // [RULE_16]
				end else if (state_reg == ST_BURST && bit_cnt_reg == 5'h11 && burst_idx_reg == k[3:0]) begin
					unread_reg[k] <= 1'b0; // [RULE_16]
				end
			end
			new_sample_flag_o <= unread_reg;
			error_alarm_flag_o <= err_any;
			if (cs_n) begin
				bit_cnt_reg <= 5'h00;
				// A cut burst ends here as well, so the next frame starts clean
				if (state_reg != ST_IDLE) begin
					state_reg <= ST_IDLE;
				end
			end else begin
				case (state_reg)
					ST_IDLE: begin
						state_reg <= ST_SHIFT;
						shift_out_reg <= resp_reg;
						spi_miso_o <= resp_reg[15];
						bit_cnt_reg <= 5'h00;
					end
					ST_SHIFT: begin
						if (sclk_rise) begin
							shift_in_reg <= {shift_in_reg[14:0], mosi_sync_reg[1]};
							bit_cnt_reg <= bit_cnt_reg + 5'h01;
						end
						if (sclk_fall && bit_cnt_reg != 5'h10) begin
							shift_out_reg <= {shift_out_reg[14:0], 1'b0};
							spi_miso_o <= shift_out_reg[15];
						end
						// Count 16 reached: step to 17, decode once there, then park at 18, or go to 19 for a burst command
						if (bit_cnt_reg == 5'h10) begin
							bit_cnt_reg <= 5'h11;
						end
						if (bit_cnt_reg == 5'h11) begin
							bit_cnt_reg <= 5'h12;
							if (cmd_write) begin
								case (cmd_addr)
									`IORB_ADDR_ROT_OFF: rot_off_reg[7:0] <= shift_in_reg[7:0];
									`IORB_ADDR_ROT_OFF + 7'h01: rot_off_reg[15:8] <= {3'b000, shift_in_reg[4:0]};
									`IORB_ADDR_ACCX_OFF: accx_off_reg[7:0] <= shift_in_reg[7:0];
									`IORB_ADDR_ACCX_OFF + 7'h01: accx_off_reg[15:8] <= {4'h0, shift_in_reg[3:0]};
									`IORB_ADDR_ACCY_OFF: accy_off_reg[7:0] <= shift_in_reg[7:0];
									`IORB_ADDR_ACCY_OFF + 7'h01: accy_off_reg[15:8] <= {4'h0, shift_in_reg[3:0]};
									`IORB_ADDR_ACCZ_OFF: accz_off_reg[7:0] <= shift_in_reg[7:0];
									`IORB_ADDR_ACCZ_OFF + 7'h01: accz_off_reg[15:8] <= {4'h0, shift_in_reg[3:0]};
									default: resp_reg <= resp_reg;
								endcase
								resp_reg <= 16'h0000;
							end else if (cmd_addr == `IORB_ADDR_BURST) begin
								state_reg <= ST_BURST; // [RULE_15]
								burst_idx_reg <= 4'h0;
								bit_cnt_reg <= 5'h13;
							end else if (out_index(cmd_addr) != 4'hF) begin
								resp_reg <= out_word(out_index(cmd_addr), mem_rd_data,
									unread_reg[out_index(cmd_addr)], err_any);
							end else begin
								case (cmd_addr)
									`IORB_ADDR_ROT_OFF: resp_reg <= rot_off_reg;
									`IORB_ADDR_PITCH_OFF: resp_reg <= pitch_align_reg;
									`IORB_ADDR_ROLL_OFF: resp_reg <= roll_align_reg;
									`IORB_ADDR_ACCX_OFF: resp_reg <= accx_off_reg;
									`IORB_ADDR_ACCY_OFF: resp_reg <= accy_off_reg;
									`IORB_ADDR_ACCZ_OFF: resp_reg <= accz_off_reg;
									default: resp_reg <= 16'h0000;
								endcase
							end
						end
					end
					ST_BURST: begin
						// Word load: memory read data is ready one cycle after the index settles
						if (bit_cnt_reg == 5'h13) begin
							bit_cnt_reg <= 5'h14;
						end else if (bit_cnt_reg == 5'h14) begin
							shift_out_reg <= out_word(burst_idx_reg, mem_rd_data, unread_reg[burst_idx_reg], err_any);
							bit_cnt_reg <= 5'h00;
						end else begin
							if (sclk_fall) begin
								spi_miso_o <= shift_out_reg[15];
								shift_out_reg <= {shift_out_reg[14:0], 1'b0};
							end
							if (sclk_rise) begin
								bit_cnt_reg <= bit_cnt_reg + 5'h01;
							end
							if (bit_cnt_reg == 5'h10) begin
								bit_cnt_reg <= 5'h11;
							end
							// Word done: clear its flag, advance in address order
							if (bit_cnt_reg == 5'h11) begin
								if (burst_idx_reg == 4'h8) begin
									state_reg <= ST_IDLE; // [RULE_15]
									resp_reg <= 16'h0000;
									bit_cnt_reg <= 5'h12;
								end else begin
									burst_idx_reg <= burst_idx_reg + 4'h1;
									bit_cnt_reg <= 5'h13;
								end
							end
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // iorb_regs

// ### test/iorb_regs_properties.sv
/*
 Port checker of the inertial output and offset bank.
 Assumes: bound to iorb_regs; one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module iorb_regs_props (
	input wire clk_sys_i,
	input wire srst_i,
	input wire sample_valid_i,
	input wire [15:0] diagnostic_status_i,
	input wire spi_sclk_i,
	input wire spi_cs_n_i,
	input wire spi_miso_o,
	input wire [8:0] new_sample_flag_o,
	input wire error_alarm_flag_o
);
	default clocking dc @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);
	reg [7:0] since_sample_reg;
	reg [7:0] cs_high_reg;
	reg [7:0] since_fall_reg;
	reg sclk_last_reg;
	// Saturating ages, so a long idle never wraps back into a watched window
	always @(posedge clk_sys_i) begin
		sclk_last_reg <= spi_sclk_i;
		if (srst_i) begin
			since_sample_reg <= 8'hFF;
			cs_high_reg <= 8'h00;
			since_fall_reg <= 8'hFF;
		end else begin
			since_sample_reg <= sample_valid_i ? 8'h00 : since_sample_reg + {7'h00, since_sample_reg != 8'hFF};
			cs_high_reg <= spi_cs_n_i ? cs_high_reg + {7'h00, cs_high_reg != 8'hFF} : 8'h00;
			since_fall_reg <= (sclk_last_reg && !spi_sclk_i) ? 8'h00 : since_fall_reg + {7'h00, since_fall_reg != 8'hFF};
		end
	end
	// A sample taken while the serial port has long been idle
	sequence s_quiet_sample;
		sample_valid_i && cs_high_reg > 8'h08;
	endsequence
	// Nine words stored one per cycle, then the registered flag copy
	sequence s_all_flags;
		##[1:14] (&new_sample_flag_o);
	endsequence
	a_flags_all_set: assert property (s_quiet_sample |-> s_all_flags)
		else $error("new-data flags not all set after a sample");
	a_flag_rise_cause: assert property ((|(new_sample_flag_o & ~$past(new_sample_flag_o))) |-> since_sample_reg <= 8'h0E)
		else $error("new-data flag rose without a sample");
	a_flag_fall_cause: assert property (cs_high_reg > 8'h08 |-> !(|($past(new_sample_flag_o) & ~new_sample_flag_o)))
		else $error("new-data flag cleared without a read");
	a_flags_hold_idle: assert property (cs_high_reg > 8'h08 && since_sample_reg > 8'h0E |-> $stable(new_sample_flag_o))
		else $error("new-data flags moved while idle");
	a_err_flag_set: assert property (|diagnostic_status_i |=> error_alarm_flag_o)
		else $error("alarm flag low with status set");
	a_err_flag_clear: assert property (diagnostic_status_i == 16'h0000 |=> !error_alarm_flag_o)
		else $error("alarm flag high with status clear");
	a_reset_clears: assert property (disable iff (1'b0) srst_i |=> new_sample_flag_o == 9'h000 && !error_alarm_flag_o && !spi_miso_o)
		else $error("outputs not cleared by reset");
	// Late in a low phase the data bit must already have settled
	a_miso_steady: assert property (!spi_cs_n_i && !spi_sclk_i && since_fall_reg >= 8'h05 |-> $stable(spi_miso_o))
		else $error("serial data moved late in low phase");
endmodule // iorb_regs_props

bind iorb_regs iorb_regs_props u_props (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .sample_valid_i(sample_valid_i),
	.diagnostic_status_i(diagnostic_status_i), .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
	.spi_miso_o(spi_miso_o), .new_sample_flag_o(new_sample_flag_o), .error_alarm_flag_o(error_alarm_flag_o));

// ### test/iorb_spi_host.sv
/*
 Host serial master model for the bank's serial pins.
 Assumes: clock idles high, bits sampled on its rise; tasks are entered on a falling system clock edge.
*/
`timescale 1ns/1ps
module iorb_spi_host #(
	parameter int HALF = 8
) (
	input wire clk_sys_i,
	input wire spi_miso_i,
	output logic spi_sclk_o,
	output logic spi_cs_n_o,
	output logic spi_mosi_o
);
	initial begin
		spi_sclk_o = 1'b1;
		spi_cs_n_o = 1'b1;
		spi_mosi_o = 1'b0;
	end
	// MSB first; the slave resynchronises the pins, so a half period spans HALF system clocks
	task automatic shift(input logic [15:0] tx, output logic [15:0] rx);
		for (int i = 15; i >= 0; i--) begin
			spi_sclk_o = 1'b0;
			spi_mosi_o = tx[i];
			repeat (HALF) @(negedge clk_sys_i);
			rx[i] = spi_miso_i;
			spi_sclk_o = 1'b1;
			repeat (HALF) @(negedge clk_sys_i);
		end
	endtask
	task automatic open_frame();
		@(negedge clk_sys_i);
		spi_cs_n_o = 1'b0;
		repeat (HALF) @(negedge clk_sys_i);
	endtask
	// Released data line is inverted so a stale bit cannot pass for a real one
	task automatic close_frame();
		spi_cs_n_o = 1'b1;
		spi_mosi_o = ~spi_mosi_o;
		repeat (HALF) @(negedge clk_sys_i);
	endtask
	task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
		open_frame();
		shift(tx, rx);
		close_frame();
	endtask
	// Command word, then nine words with an extra clock period between them
	task automatic burst(output logic [15:0] w [9]);
		logic [15:0] d;
		open_frame();
		shift(16'h3E00, d);
		for (int i = 0; i < 9; i++) begin
			repeat (2 * HALF) @(negedge clk_sys_i);
			shift(16'h0000, w[i]);
		end
		close_frame();
	endtask
endmodule // iorb_spi_host

// ### test/test_inertial_output_and_offset_regs.sv
/*
 Self-checking bench of the inertial output and offset bank.
 Assumes: the host model drives the serial pins; inputs change on falling clock edges.
*/
`timescale 1ns/1ps
module test_inertial_output_and_offset_regs;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic sample_valid_i = 1'b0;
	logic align_load_i = 1'b0;
	logic [2:0] range_sel_i = 3'h4;
	logic [15:0] diagnostic_status_i = 16'h0000;
	logic [15:0] pitch_align_i = 16'h0000;
	logic [15:0] roll_align_i = 16'h0000;
	logic [15:0] raw [9] = '{default: 16'h0000};
	logic [15:0] rd_word;
	wire spi_sclk;
	wire spi_cs_n;
	wire spi_mosi;
	wire spi_miso;
	wire [8:0] new_sample_flag;
	wire error_alarm_flag;
	int num_errors = 0;
	int tests_run = 0;
	int cycle_count = 0;
	localparam logic [6:0] OUT_ADDR [9] = '{7'h02, 7'h04, 7'h0A, 7'h0C, 7'h0E, 7'h10, 7'h12, 7'h14, 7'h16};
	localparam logic [15:0] OUT_MASK [9] = '{16'h0FFF, 16'h3FFF, 16'h3FFF, 16'h3FFF, 16'h3FFF, 16'h0FFF, 16'h1FFF,
		16'h1FFF, 16'h0FFF};

	always #4 clk_sys_i = ~clk_sys_i;

	iorb_regs uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .sample_valid_i(sample_valid_i), .supply_raw_i(raw[0]),
		.rotation_raw_i(raw[1][13:0]), .accel_x_raw_i(raw[2][13:0]), .accel_y_raw_i(raw[3][13:0]),
		.accel_z_raw_i(raw[4][13:0]), .temperature_raw_i(raw[5]), .pitch_raw_i(raw[6][12:0]),
		.roll_raw_i(raw[7][12:0]), .aux_raw_i(raw[8]), .range_sel_i(range_sel_i),
		.diagnostic_status_i(diagnostic_status_i), .align_load_i(align_load_i), .pitch_align_i(pitch_align_i),
		.roll_align_i(roll_align_i), .spi_sclk_i(spi_sclk), .spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi),
		.spi_miso_o(spi_miso), .new_sample_flag_o(new_sample_flag), .error_alarm_flag_o(error_alarm_flag));
	iorb_spi_host host (.clk_sys_i(clk_sys_i), .spi_miso_i(spi_miso), .spi_sclk_o(spi_sclk), .spi_cs_n_o(spi_cs_n),
		.spi_mosi_o(spi_mosi));

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Output word: two flags above the data field, unused middle bits ignored
	task automatic chk_out(input int i, input logic [1:0] flags, input logic [15:0] seen);
		chk("output word", {flags, 14'h0000} | (raw[i] & OUT_MASK[i]), seen & (OUT_MASK[i] | 16'hC000));
	endtask
	// Lower byte first, then the odd address for the upper byte
	task automatic wr16(input logic [6:0] a, input logic [15:0] v);
		logic [15:0] d;
		host.frame({1'b1, a, v[7:0]}, d);
		host.frame({1'b1, a + 7'h01, v[15:8]}, d);
	endtask
	// The answer arrives in the frame after the request
	task automatic rd16(input logic [6:0] a, output logic [15:0] v);
		host.frame({1'b0, a, 8'h00}, v);
		host.frame(16'h0000, v);
	endtask
	task automatic apply(input logic [15:0] v [9]);
		@(negedge clk_sys_i);
		raw = v;
		sample_valid_i = 1'b1;
		@(negedge clk_sys_i);
		sample_valid_i = 1'b0;
		repeat (16) @(negedge clk_sys_i);
	endtask

	task automatic t_reset_regs();
		logic [6:0] a [5] = '{7'h1A, 7'h20, 7'h22, 7'h24, 7'h18};
		for (int i = 0; i < 5; i++) begin
			rd16(a[i], rd_word);
			chk("reset value", 16'h0000, rd_word);
		end
		chk("flags after reset", 16'h0000, {6'h00, error_alarm_flag, new_sample_flag});
	endtask
	task automatic t_formats();
		diagnostic_status_i = 16'h0004;
		apply('{16'h0814, 16'h2890, 16'h157C, 16'h2A84, 16'h0001, 16'h0FFF, 16'h1803, 16'h0FFB, 16'h0FFF});
		chk("alarm flag", 16'h0001, {15'h0000, error_alarm_flag});
		for (int i = 0; i < 9; i++) begin
			rd16(OUT_ADDR[i], rd_word);
			chk_out(i, 2'h3, rd_word);
		end
		chk("flags after reads", 16'h0000, {7'h00, new_sample_flag});
		rd16(OUT_ADDR[0], rd_word);
		chk_out(0, 2'h1, rd_word);
	endtask
	task automatic t_burst();
		logic [15:0] w [9];
		diagnostic_status_i = 16'h0000;
		apply('{16'h07AC, 16'h0001, 16'h3FFF, 16'h0002, 16'h3FFE, 16'h024C, 16'h0002, 16'h1FFF, 16'h04D9});
		host.burst(w);
		for (int i = 0; i < 9; i++) begin
			chk_out(i, 2'h2, w[i]);
		end
		chk("flags after burst", 16'h0000, {7'h00, new_sample_flag});
	endtask
	// Alignment words come only from the load strobe; serial writes must not land
	task automatic t_align();
		pitch_align_i = 16'hFFFF;
		roll_align_i = 16'h0155;
		align_load_i = 1'b1;
		@(negedge clk_sys_i);
		align_load_i = 1'b0;
		wr16(7'h1C, 16'h0000);
		rd16(7'h1C, rd_word);
		chk("pitch alignment", 16'h03FF, rd_word);
		rd16(7'h1E, rd_word);
		chk("roll alignment", 16'h0155, rd_word);
	endtask
	task automatic t_offsets();
		logic [2:0] code [3] = '{3'h4, 3'h2, 3'h1};
		wr16(7'h20, 16'hFFFF);
		rd16(7'h20, rd_word);
		chk("accel offset", 16'h0FFF, rd_word);
		wr16(7'h1A, 16'hFFF8);
		rd16(7'h1A, rd_word);
		chk("rotation offset", 16'h1FF8, rd_word);
		for (int r = 0; r < 3; r++) begin
			range_sel_i = code[r];
			apply('{16'h0814, 16'h0064, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000});
			rd16(7'h04, rd_word);
			chk("rotation with offset", 16'h8064 - (16'h0002 << r), rd_word);
			rd16(7'h0A, rd_word);
			chk("accel with offset", 16'h8001, rd_word);
		end
	endtask

	// Cuts a hang short; the full run needs about 20000 cycles
	always @(posedge clk_sys_i) begin
		cycle_count++;
		if (cycle_count == 60000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		repeat (2) @(negedge clk_sys_i);
		srst_i = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		t_reset_regs();
		t_formats();
		t_burst();
		t_align();
		t_offsets();
		conclude();
	end
endmodule // test_inertial_output_and_offset_regs
